// >>> design/ppb_block_page_unit.sv
// Operation
// R1 - Selector 09H starts block; address from operand, outcome in result
// R2 - Only privilege level 0 may run the leaf
// R3 - Linear address uses data segment base; no segment override
// R4 - Page address not 4KByte aligned gives protection fault 0
// R5 - Address outside page cache gives page fault with operand
// R6 - After address checks clear flags, zero and carry, result
// R7 - Page being written: zero flag, conflict code, no change
// R8 - Invalid entry: zero flag, invalid code, no change
// R9 - Unblockable type: carry flag, control or unblockable code
// R10 - Already blocked: carry flag, already-blocked code, no change
// R11 - All checks pass: set blocked bit, zero result, flags clear
// R12 - Epoch tracking holds control page: epoch-locked code, retry
// R13 - Shared access; conflict reported as code, never a fault
// R14 - Runs concurrently with accept, modify, add, extend, init, track
// R15 - Protected mode: offset beyond segment limit gives fault 0
// R16 - 64-bit mode: non-canonical operand gives fault 0
// R17 - Checks in fixed order; first failure is sole outcome
// R18 - Map entry update atomic with the conflict check
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module ppb_block_page_unit
  import ppb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic WR_BUSY,
  input wire logic [IDX_W-1:0] WR_BUSY_IDX,
  input wire logic EPOCH_LOCKED,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Software-visible configuration
  logic [7:0] selector, next_selector;
  logic [1:0] cpl, next_cpl;
  logic mode64, next_mode64;
  logic [31:0] oper_lo, oper_hi, seg_base, seg_limit, cache_base;
  logic [31:0] next_oper_lo, next_oper_hi, next_seg_base, next_seg_limit;
  logic [31:0] next_cache_base, next_prdata;
  logic [IDX_W-1:0] map_sel, next_map_sel;
  logic [INT_W-1:0] int_mask, next_int_mask;
  logic next_pready, next_pslverr;

  // Leaf state and results
  ppb_state_t state, next_state;
  ppb_flags_t flags, next_flags;
  ppb_fault_t fault, next_fault;
  logic [31:0] result, next_result, fault_addr, next_fault_addr;
  logic [INT_W-1:0] int_stat, next_int_stat;
  logic [IDX_W-1:0] page_idx, next_page_idx;
  logic next_irq;

  // Page cache map and its write port
  ppb_entry_t map [CACHE_PAGES];
  ppb_entry_t map_wdata, cur;
  logic [IDX_W-1:0] map_widx;
  logic map_we, leaf_we;

  // Bus decode terms and address arithmetic
  logic xfer, wr, mapped, start, canonical, resident;
  logic [31:0] wmerge, rd_word, linear, cache_off;

  // Bus decode and read mux
  always_comb
  begin
    xfer = PSEL && PENABLE && PREADY;
    wr = xfer && PWRITE;
    case (PADDR)
      ADDR_CTRL: rd_word = {21'h00000, mode64, cpl, selector};
      ADDR_OPER_LO: rd_word = oper_lo;
      ADDR_OPER_HI: rd_word = oper_hi;
      ADDR_SEG_BASE: rd_word = seg_base;
      ADDR_SEG_LIMIT: rd_word = seg_limit;
      ADDR_RESULT: rd_word = result;
      ADDR_FLAGS: rd_word = {26'h0000000, flags};
      ADDR_FAULT: rd_word = {30'h00000000, fault};
      ADDR_FAULT_ADDR: rd_word = fault_addr;
      ADDR_INT_STAT: rd_word = {28'h0000000, int_stat};
      ADDR_INT_MASK: rd_word = {28'h0000000, int_mask};
      ADDR_CACHE_BASE: rd_word = cache_base;
      ADDR_MAP_SEL: rd_word = {28'h0000000, map_sel};
      ADDR_MAP_DATA: rd_word = {27'h0000000, map[map_sel]};
      ADDR_STATUS: rd_word = {31'h00000000, state != ST_IDLE};
      default: rd_word = 32'h0000_0000;
    endcase
    case (PADDR)
      ADDR_CTRL, ADDR_OPER_LO, ADDR_OPER_HI, ADDR_SEG_BASE,
      ADDR_SEG_LIMIT, ADDR_RESULT, ADDR_FLAGS, ADDR_FAULT,
      ADDR_FAULT_ADDR, ADDR_INT_STAT, ADDR_INT_MASK, ADDR_CACHE_BASE,
      ADDR_MAP_SEL, ADDR_MAP_DATA, ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    wmerge = merge(rd_word, PWDATA, PSTRB);
    start = wr && mapped && PADDR == ADDR_CTRL && wmerge[CTRL_GO];
  end

  // Bus answer and configuration writes
  always_comb
  begin
    next_pready = PSEL && PENABLE && !PREADY;
    next_prdata = PRDATA;
    next_pslverr = 1'b0; // Error only stands beside the ready pulse
    if (PSEL && PENABLE && !PREADY)
    begin
      next_prdata = PWRITE ? 32'h0000_0000 : rd_word;
      next_pslverr = !mapped;
    end
    next_selector = selector;
    next_cpl = cpl;
    next_mode64 = mode64;
    next_oper_lo = oper_lo;
    next_oper_hi = oper_hi;
    next_seg_base = seg_base;
    next_seg_limit = seg_limit;
    next_cache_base = cache_base;
    next_map_sel = map_sel;
    next_int_mask = int_mask;
    if (wr && mapped && state == ST_IDLE)
    begin
      case (PADDR)
        ADDR_CTRL:
        begin
          next_selector = wmerge[CTRL_SEL_LSB +: 8];
          next_cpl = wmerge[CTRL_CPL_LSB +: 2];
          next_mode64 = wmerge[CTRL_MODE64];
        end
        ADDR_OPER_LO: next_oper_lo = wmerge;
        ADDR_OPER_HI: next_oper_hi = wmerge;
        ADDR_SEG_BASE: next_seg_base = wmerge;
        ADDR_SEG_LIMIT: next_seg_limit = wmerge;
        ADDR_CACHE_BASE: next_cache_base = wmerge;
        ADDR_MAP_SEL: next_map_sel = wmerge[IDX_W-1:0];
        default: ;
      endcase
    end
    if (wr && PADDR == ADDR_INT_MASK)
    begin
      next_int_mask = wmerge[INT_W-1:0];
    end
  end

  // Bus and configuration registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA <= RST_WORD;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      selector <= 8'h00;
      cpl <= 2'h0;
      mode64 <= 1'b0;
      oper_lo <= RST_WORD;
      oper_hi <= RST_WORD;
      seg_base <= RST_WORD;
      seg_limit <= RST_SEG_LIMIT;
      cache_base <= RST_WORD;
      map_sel <= '0;
      int_mask <= '0;
    end
    else if (CE)
    begin
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      selector <= next_selector;
      cpl <= next_cpl;
      mode64 <= next_mode64;
      oper_lo <= next_oper_lo;
      oper_hi <= next_oper_hi;
      seg_base <= next_seg_base;
      seg_limit <= next_seg_limit;
      cache_base <= next_cache_base;
      map_sel <= next_map_sel;
      int_mask <= next_int_mask;
    end
  end

  // Linear address, canonical form and cache residency
  always_comb
  begin
    linear = mode64 ? oper_lo : seg_base + oper_lo; // R3
    cache_off = linear - cache_base;
    canonical = (&oper_hi[31:15]) || !(|oper_hi[31:15]); // R16
    resident = linear >= cache_base && cache_off < CACHE_SPAN
               && (!mode64 || oper_hi == 32'h0000_0000); // R5
    cur = map[page_idx];
  end

  // Leaf sequencer: address checks, then page checks and commit
  always_comb
  begin
    next_state = state;
    next_flags = flags;
    next_result = result;
    next_fault = fault;
    next_fault_addr = fault_addr;
    next_page_idx = page_idx;
    next_int_stat = int_stat;
    leaf_we = 1'b0;
    if (wr && PADDR == ADDR_INT_STAT)
    begin
      next_int_stat = int_stat & ~wmerge[INT_W-1:0];
    end
    if (wr && PADDR == ADDR_FLAGS && state == ST_IDLE)
    begin
      next_flags = wmerge[5:0];
    end
    case (state)
      ST_IDLE:
      begin
        if (start && wmerge[CTRL_SEL_LSB +: 8] == LEAF_BLOCK_PAGE) // R1
        begin
          next_state = ST_ADDR;
        end
        else if (start)
        begin
          next_int_stat[INT_IGNORED] = 1'b1;
        end
      end
      ST_ADDR:
      begin
        next_state = ST_IDLE;
        next_fault = '0;
        if (cpl != 2'h0) // R2
        begin
          next_fault.gp_fault = 1'b1;
          next_int_stat[INT_FAULT] = 1'b1;
        end
        else if (mode64 && !canonical) // R16
        begin
          next_fault.gp_fault = 1'b1;
          next_int_stat[INT_FAULT] = 1'b1;
        end
        else if (!mode64 && oper_lo > seg_limit) // R15
        begin
          next_fault.gp_fault = 1'b1;
          next_int_stat[INT_FAULT] = 1'b1;
        end
        else if (linear[PAGE_SHIFT-1:0] != '0) // R4 R17
        begin
          next_fault.gp_fault = 1'b1;
          next_int_stat[INT_FAULT] = 1'b1;
        end
        else if (!resident) // R5 R17
        begin
          next_fault.page_fault = 1'b1;
          next_fault_addr = oper_lo;
          next_int_stat[INT_FAULT] = 1'b1;
        end
        else
        begin
          next_flags = '0; // R6
          next_result = CODE_NONE; // R6
          next_page_idx = cache_off[PAGE_SHIFT +: IDX_W];
          next_state = ST_PAGE;
        end
      end
      ST_PAGE:
      begin
        next_state = ST_IDLE;
        next_int_stat[INT_DONE] = 1'b1;
        // Only page writers raise the busy pin; other leaves never do
        if (WR_BUSY && WR_BUSY_IDX == page_idx) // R7 R13 R14 R17
        begin
          next_flags.zf = 1'b1;
          next_result = code_page_conflict;
        end
        else if (EPOCH_LOCKED) // R12
        begin
          next_flags.zf = 1'b1;
          next_result = code_epoch_locked;
        end
        else if (!cur.valid) // R8
        begin
          next_flags.zf = 1'b1;
          next_result = code_page_invalid;
        end
        else if (cur.ptype != type_regular
                 && cur.ptype != type_thread_control
                 && cur.ptype != type_trimmed) // R9
        begin
          next_flags.cf = 1'b1;
          next_result = cur.ptype == type_enclave_control
                        ? code_page_is_control : code_type_unblockable;
        end
        else if (cur.blocked) // R10
        begin
          next_flags.cf = 1'b1;
          next_result = code_already_blocked;
        end
        else
        begin
          leaf_we = 1'b1; // R11 R18
        end
        if (!leaf_we)
        begin
          next_int_stat[INT_ERRCODE] = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_irq = |(next_int_stat & int_mask);
  end

  // Leaf state registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      flags <= '0;
      result <= RST_WORD;
      fault <= '0;
      fault_addr <= RST_WORD;
      page_idx <= '0;
      int_stat <= '0;
      IRQ <= 1'b0;
    end
    else if (CE)
    begin
      state <= next_state;
      flags <= next_flags;
      result <= next_result;
      fault <= next_fault;
      fault_addr <= next_fault_addr;
      page_idx <= next_page_idx;
      int_stat <= next_int_stat;
      IRQ <= next_irq;
    end
  end

  // Map write select: leaf commit wins over a software entry write
  always_comb
  begin
    map_we = 1'b0;
    map_widx = map_sel;
    map_wdata = wmerge[4:0];
    if (leaf_we)
    begin
      map_we = 1'b1;
      map_widx = page_idx;
      map_wdata = cur;
      map_wdata.blocked = 1'b1; // R11 R18
    end
    else if (wr && PADDR == ADDR_MAP_DATA && state == ST_IDLE)
    begin
      map_we = 1'b1;
    end
  end

  // Page cache map storage
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < CACHE_PAGES; i++)
      begin
        map[i] <= '0;
      end
    end
    else if (CE && map_we)
    begin
      map[map_widx] <= map_wdata;
    end
  end
endmodule

// >>> design/ppb_pkg.sv
package ppb_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPER_LO = 8'h04;
  localparam logic [7:0] ADDR_OPER_HI = 8'h08;
  localparam logic [7:0] ADDR_SEG_BASE = 8'h0c;
  localparam logic [7:0] ADDR_SEG_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_RESULT = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_FAULT = 8'h1c;
  localparam logic [7:0] ADDR_FAULT_ADDR = 8'h20;
  localparam logic [7:0] ADDR_INT_STAT = 8'h24;
  localparam logic [7:0] ADDR_INT_MASK = 8'h28;
  localparam logic [7:0] ADDR_CACHE_BASE = 8'h2c;
  localparam logic [7:0] ADDR_MAP_SEL = 8'h30;
  localparam logic [7:0] ADDR_MAP_DATA = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;

  // Control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_CPL_LSB = 8;
  localparam int CTRL_MODE64 = 10;
  localparam int CTRL_GO = 31;

  // Leaf selector and page geometry
  localparam logic [7:0] LEAF_BLOCK_PAGE = 8'h09;
  localparam int PAGE_SHIFT = 12;
  localparam int IDX_W = 4;
  localparam int CACHE_PAGES = 16;
  localparam logic [31:0] CACHE_SPAN = 32'h0001_0000;

  // Outcome codes returned in the result register
  localparam logic [31:0] CODE_NONE = 32'h0000_0000;
  localparam logic [31:0] code_page_invalid = 32'h0000_0001;
  localparam logic [31:0] code_already_blocked = 32'h0000_0002;
  localparam logic [31:0] code_type_unblockable = 32'h0000_0003;
  localparam logic [31:0] code_page_is_control = 32'h0000_0004;
  localparam logic [31:0] code_epoch_locked = 32'h0000_0005;
  localparam logic [31:0] code_page_conflict = 32'h0000_0006;

  // Interrupt status bits
  localparam int INT_W = 4;
  localparam int INT_DONE = 0;
  localparam int INT_ERRCODE = 1;
  localparam int INT_FAULT = 2;
  localparam int INT_IGNORED = 3;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_SEG_LIMIT = 32'hffff_ffff;

  typedef enum logic [2:0] {
    type_enclave_control = 3'h0,
    type_thread_control = 3'h1,
    type_regular = 3'h2,
    type_trimmed = 3'h3,
    type_other = 3'h4
  } ppb_ptype_t;

  typedef struct packed {
    logic valid;
    logic blocked;
    ppb_ptype_t ptype;
  } ppb_entry_t;

  typedef struct packed {
    logic sf;
    logic of_;
    logic af;
    logic pf;
    logic cf;
    logic zf;
  } ppb_flags_t;

  typedef struct packed {
    logic page_fault;
    logic gp_fault;
  } ppb_fault_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_PAGE = 3'b100
  } ppb_state_t;

endpackage

// >>> sim/ppb_block_page_unit_properties.sv
`timescale 1ns/1ns
module ppb_block_page_checker
  import ppb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Bus answer timing
  ready_pulse_a: assert property (
    PREADY && CE |=> !PREADY)
    else $error("ready held too long");
  ready_wait_a: assert property (
    (PSEL && !PENABLE && CE) ##1 (PSEL && PENABLE && CE)
    |-> !PREADY ##1 PREADY)
    else $error("answer not after one wait state");
  err_unmapped_a: assert property (
    PREADY && (PADDR > ADDR_STATUS || PADDR[1:0] != 2'h0) |-> PSLVERR)
    else $error("unmapped access not refused");
  err_ready_a: assert property (
    PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside an answer");
  data_hold_a: assert property (
    !PREADY |-> $stable(PRDATA))
    else $error("read data moved between answers");
  // Register contents seen on reads, and IRQ after a mask write of zero
  go_reads_zero_a: assert property (
    PREADY && !PWRITE && PADDR == ADDR_CTRL |-> !PRDATA[CTRL_GO])
    else $error("start bit read back");
  fault_single_a: assert property (
    PREADY && !PWRITE && PADDR == ADDR_FAULT |-> PRDATA[1:0] != 2'h3)
    else $error("two faults reported");
  irq_masked_a: assert property (
    PREADY && PWRITE && PADDR == ADDR_INT_MASK && PSTRB[0] && CE
    && PWDATA[3:0] == 4'h0 |=> ##1 !IRQ)
    else $error("interrupt while fully masked");
  // Main scenarios
  cover property ($rose(IRQ));
  cover property (PREADY && PSLVERR);
  cover property (!CE ##1 CE);
endmodule

bind ppb_block_page_unit ppb_block_page_checker u_chk (.CLK, .RST, .CE,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY,
  .PSLVERR, .IRQ);

// >>> sim/ppb_block_page_unit_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ppb_block_page_unit_tb_top
  import ppb_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hold_page = 1'b0, hold_track = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lo, hi, ctl;
  logic [3:0] pstrb = 4'hf, strb = 4'hf;
  logic [IDX_W-1:0] page_idx = 4'h0, wr_busy_idx, bidx, ix;
  logic [31:0] base = 32'h0010_0000, cbase = 32'h0030_0000;
  logic [31:0] limit = 32'hffff_ff00;
  logic pready, pslverr, irq, wr_busy, epoch_locked, er, busy, lock;
  logic mval[16], mblk[16];
  logic [2:0] mtype[16];
  int failures = 0, checked = 0, cyc = 0, r;

  // Free-running clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  ppb_block_page_unit u_dut (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .WR_BUSY(wr_busy), .WR_BUSY_IDX(wr_busy_idx),
    .EPOCH_LOCKED(epoch_locked), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  ppb_writer_model u_part (.clk(clk), .rst(rst), .hold_page(hold_page),
    .page_idx(page_idx), .hold_track(hold_track), .wr_busy(wr_busy),
    .wr_idx(wr_busy_idx), .epoch_locked(epoch_locked));

  // One bus transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // New random map entry, mirrored in the model
  task automatic put(input logic [3:0] i);
    mval[i] = ($urandom % 4) != 0;
    mblk[i] = 1'($urandom % 2);
    mtype[i] = 3'($urandom % 5);
    apb(1'b1, ADDR_MAP_SEL, {28'h0, i});
    apb(1'b1, ADDR_MAP_DATA, {27'h0, mval[i], mblk[i], mtype[i]});
  endtask

  // Run one leaf and compare every result with the model
  task automatic leaf(input logic [3:0] m);
    logic [31:0] lin, code;
    logic [1:0] flt;
    logic [3:0] st, ix;
    logic zf, cf;
    lin = ctl[CTRL_MODE64] ? lo : base + lo;
    ix = 4'((lin - cbase) >> PAGE_SHIFT);
    flt = 2'h0;
    code = CODE_NONE;
    if (ctl[9:8] != 2'h0)
      flt = 2'h1;
    else if (ctl[CTRL_MODE64] ? hi[31:15] != {17{hi[15]}} : lo > limit)
      flt = 2'h1;
    else if (lin[11:0] != 12'h0)
      flt = 2'h1;
    else if ((ctl[CTRL_MODE64] && hi != 0) || lin - cbase >= CACHE_SPAN)
      flt = 2'h2;
    else if (busy && bidx == ix)
      code = code_page_conflict;
    else if (lock)
      code = code_epoch_locked;
    else if (!mval[ix])
      code = code_page_invalid;
    else if (mtype[ix] == type_enclave_control)
      code = code_page_is_control;
    else if (mtype[ix] == type_other)
      code = code_type_unblockable;
    else if (mblk[ix])
      code = code_already_blocked;
    else
      mblk[ix] = 1'b1;
    zf = code inside {code_page_invalid, code_epoch_locked,
      code_page_conflict};
    cf = code inside {code_already_blocked, code_type_unblockable,
      code_page_is_control};
    st = flt != 2'h0 ? 4'h4 : (code != CODE_NONE ? 4'h3 : 4'h1);
    apb(1'b1, ADDR_OPER_LO, lo);
    apb(1'b1, ADDR_OPER_HI, hi);
    apb(1'b1, ADDR_INT_STAT, 32'hf);
    apb(1'b1, ADDR_INT_MASK, {28'h0, m});
    apb(1'b1, ADDR_FLAGS, 32'h3f);
    apb(1'b1, ADDR_CTRL, ctl);
    ce <= m[3];
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rd = 32'h1;
    for (int n = 0; n < 20 && rd[0] !== 1'b0; n++)
      apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    apb(1'b0, ADDR_FAULT, 32'h0);
    `CHK(rd, {30'h0, flt})
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK(rd, flt != 2'h0 ? 32'h3f : {30'h0, cf, zf})
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    `CHK(rd, {28'h0, st})
    `CHK(irq, |(st & m))
    if (flt == 2'h2)
    begin
      apb(1'b0, ADDR_FAULT_ADDR, 32'h0);
      `CHK(rd, lo)
    end
    if (flt == 2'h0)
    begin
      apb(1'b0, ADDR_RESULT, 32'h0);
      `CHK(rd, code)
      apb(1'b1, ADDR_MAP_SEL, {28'h0, ix});
      apb(1'b0, ADDR_MAP_DATA, 32'h0);
      `CHK(rd, {27'h0, mval[ix], mblk[ix], mtype[ix]})
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      results();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'hbfca3ed9));
    busy = 1'b0;
    lock = 1'b0;
    bidx = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_MAP_DATA, 32'h0);
    `CHK(rd, RST_WORD)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    strb = 4'h1;
    apb(1'b1, ADDR_SEG_LIMIT, 32'h0);
    strb = 4'hf;
    apb(1'b0, ADDR_SEG_LIMIT, 32'h0);
    `CHK(rd, limit)
    apb(1'b1, ADDR_SEG_BASE, base);
    apb(1'b1, ADDR_CACHE_BASE, cbase);
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h8000_0008);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h8)
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    `CHK(rd, 32'h8)
    for (int i = 0; i < 16; i++)
      put(4'(i));
    // Random leaves with faults, contention and clock stalls
    for (int i = 0; i < 90; i++)
    begin
      r = $urandom % 10;
      ix = 4'($urandom);
      busy = ($urandom % 5) == 0;
      bidx = ($urandom % 2) ? ix : 4'($urandom);
      lock = ($urandom % 8) == 0;
      hold_page <= busy;
      page_idx <= bidx;
      hold_track <= lock;
      if (r > 6)
        put(ix);
      ctl = 32'h8000_0009 | ((32'($urandom) & 32'h1) << CTRL_MODE64);
      ctl = ctl | (r == 0 ? 32'h100 : 32'h0);
      lo = (ctl[CTRL_MODE64] ? cbase : cbase - base) + {ix, 12'h0};
      hi = 32'h0;
      if (r == 1)
        lo = lo + 32'h800;
      if (r == 2)
        lo = lo + CACHE_SPAN + 32'(($urandom % 2) * 16);
      if (r == 3 && ctl[CTRL_MODE64])
        hi = 32'h8000;
      else if (r == 3)
        lo = 32'hffff_ff01;
      leaf(4'($urandom));
    end
    hold_page <= 1'b0;
    hold_track <= 1'b0;
    apb(1'b1, ADDR_INT_STAT, 32'hf);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    `CHK(rd, 32'h0)
    results();
  end
endmodule

// >>> sim/ppb_writer_model.sv
`timescale 1ns/1ns
module ppb_writer_model
  import ppb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hold_page,
  input wire logic [IDX_W-1:0] page_idx,
  input wire logic hold_track,
  output logic wr_busy,
  output logic [IDX_W-1:0] wr_idx,
  output logic epoch_locked
);
  // Other writers and the epoch tracker claim pages after an edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_busy <= 1'b0;
      wr_idx <= 4'h0;
      epoch_locked <= 1'b0;
    end
    else
    begin
      wr_busy <= hold_page;
      wr_idx <= hold_page ? page_idx : ~wr_idx; // Stale index churns
      epoch_locked <= hold_track;
    end
  end
endmodule
